// ### common/pdsg_defines.vh
// Behaviour
// - Four 23-bit even/odd dividers per synthesizer
// - Divider outputs keep 50% duty, odd too
// - Coarse skew in whole synthesizer clock periods
// - Fine sub-cycle skew code for single-ended clocks
// - Stop clock on chosen rising or falling edge
// - Ten pins assignable as enable/stop controls
// - Reset loads defaults or one-time custom values
// - Written values are volatile, lost on reset
// - Same port reads back status registers
// - Bank selectable as four SE or two diff
// - Per-output slew select, fast or medium
// - Outputs start disabled; pin enables first diff output
`ifndef PDSG_DEFINES_VH
`define PDSG_DEFINES_VH
// Divider widths and reset values
`define PDSG_RATIO_W 23
`define PDSG_RATIO_RST 23'h000002
`define PDSG_RATIO_MIN 23'h000002
`define PDSG_SKEW_W 8
`define PDSG_FINE_W 3
// Control word field positions
`define PDSG_CTL_EN 0
`define PDSG_CTL_STOP 1
`define PDSG_CTL_RISE 2
`define PDSG_CTL_SLEW 3
`define PDSG_CTL_SKEW_LO 4
`define PDSG_CTL_SKEW_HI 11
`define PDSG_CTL_FINE_LO 12
`define PDSG_CTL_FINE_HI 14
`define PDSG_CTL_RST 16'h0000
// Configuration addresses
`define PDSG_A_RATIO 4'h0
`define PDSG_A_CTRL 4'h1
`define PDSG_A_BANK 8'h20
`define PDSG_A_HPDIFF 8'h21
`define PDSG_A_HPSE 8'h22
`define PDSG_A_GPIO 4'h3
`define PDSG_A_STAT_RUN 8'h40
`define PDSG_A_STAT_PIN 8'h41
`define PDSG_A_STAT_LOAD 8'h42
// Pin function codes, low nibble of a pin function word
`define PDSG_PF_NONE 4'h0
`define PDSG_PF_HPDIFF 4'h1
`define PDSG_PF_HPSE 4'h2
`define PDSG_PF_DIV_EN 4'h3
`define PDSG_PF_STOP_R 4'h4
`define PDSG_PF_STOP_F 4'h5
// Pin 2 enables the first differential output after reset
`define PDSG_GPIO2_RST 8'h01
`define PDSG_GPIO_RST 8'h00
// Bank mode and power-up load delay
`define PDSG_BANK_RST 2'h0
`define PDSG_LOAD_WAIT 2'h3
`endif

// ### src/pdsg_divider.v
`timescale 1ns/10ps
`include "pdsg_defines.vh"
// One post divider: 50% duty for any ratio, coarse skew, edge stop
module pdsg_divider (
	input wire mclk,
	input wire reset_n,
	input wire [22:0] ratio,
	input wire [7:0] skew,
	input wire [2:0] fine_in,
	input wire enable,
	input wire stop_req,
	input wire stop_rise,
	output wire clk_out,
	output reg [2:0] fine_out,
	output wire running
);
	// One-hot states
	localparam ST_STOP = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_RUN = 3'b100;
	reg [2:0] state; // Current state
	reg [22:0] act_ratio; // Ratio in use, changes only at wrap or while stopped
	reg [22:0] cnt; // Position inside the output period
	reg [7:0] wait_cnt; // Remaining skew cycles before start
	reg pos_q; // High phase, rising-edge flop
	reg neg_q; // High phase delayed half a cycle
	wire [22:0] safe_ratio;
	wire [23:0] half_sum;
	wire [22:0] half;
	wire [22:0] next_cnt;
	wire halt;
	wire rise_sel;
	wire [22:0] stop_point;

	// Ratios below two are clamped so the period is never empty
	assign safe_ratio = (ratio < `PDSG_RATIO_MIN) ? `PDSG_RATIO_MIN : ratio;
	// High length rounds up; odd ratios trim half a cycle below
	assign half_sum = {1'b0, act_ratio} + 24'h000001;
	assign half = half_sum[23:1];
	assign next_cnt = (cnt == act_ratio - 23'h000001) ? 23'h000000 :
		cnt + 23'h000001;
	// Disabling a running divider parks the clock low
	assign halt = ~enable | stop_req;
	assign rise_sel = enable & stop_rise;
	assign stop_point = rise_sel ? 23'h000000 : half;
	assign running = state[2];
	// Odd ratio: AND with half-cycle copy gives exactly N/2 high
	assign clk_out = act_ratio[0] ? (pos_q & neg_q) : pos_q;

	// Main divider sequence
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_STOP;
			act_ratio <= `PDSG_RATIO_RST;
			cnt <= 23'h000000;
			wait_cnt <= 8'h00;
			pos_q <= 1'b0;
			fine_out <= 3'h0;
		end else begin
			case (state)
			ST_STOP: begin
				// Ratio and fine code load here while parked, no runts
				act_ratio <= safe_ratio;
				fine_out <= fine_in;
				if (enable && !stop_req) begin
					state <= ST_WAIT;
					wait_cnt <= skew;
					// Parked low: next tick starts a full period at rise
					if (!pos_q) begin
						cnt <= safe_ratio - 23'h000001;
					end
				end
			end
			ST_WAIT: begin
				// Coarse skew delays the first edge by whole cycles
				if (halt) begin
					state <= ST_STOP;
				end else if (wait_cnt == 8'h00) begin
					state <= ST_RUN;
				end else begin
					wait_cnt <= wait_cnt - 8'h01;
				end
			end
			ST_RUN: begin
				cnt <= next_cnt;
				pos_q <= (next_cnt < half);
				if (next_cnt == 23'h000000) begin
					act_ratio <= safe_ratio;
				end
				// Freeze right after the chosen edge; level is then held
				if (halt && next_cnt == stop_point) begin
					state <= ST_STOP;
				end
			end
			default: begin
				state <= ST_STOP;
			end
			endcase
		end
	end

	// Falling-edge copy used only for odd ratios
	always @(negedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			neg_q <= 1'b0;
		end else begin
			neg_q <= pos_q;
		end
	end
endmodule // pdsg_divider

// ### src/pdsg_top.v
`timescale 1ns/10ps
`include "pdsg_defines.vh"
// Post divider bank with skew, edge stop, pin control and config store
module pdsg_top #(
	parameter NSYN = 4,
	parameter NDIV = 4,
	parameter NGPIO = 10
) (
	input wire mclk,
	input wire reset_n,
	input wire [NGPIO-1:0] gpio_in,
	input wire otp_use,
	input wire [NSYN*NDIV*23-1:0] otp_ratio,
	input wire [NSYN*NDIV*16-1:0] otp_ctrl,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output wire [NSYN*NDIV-1:0] div_clk,
	output wire [NSYN*NDIV*3-1:0] fine_skew,
	output reg [NSYN*NDIV-1:0] slew_fast,
	output reg [1:0] bank_mode,
	output reg [7:0] hp_diff_en,
	output reg [3:0] hp_se_en,
	output wire first_hp_differential_out_en,
	output reg load_done
);
	localparam ND = NSYN * NDIV; // Total dividers

	// Volatile configuration store
	reg [22:0] ratio_r [0:ND-1]; // Division ratio per divider
	reg [15:0] ctrl_r [0:ND-1]; // Control word per divider
	reg [7:0] gpio_func [0:NGPIO-1]; // Pin function and target
	reg [1:0] bank_r; // Bank mode, one bit per bank
	reg [7:0] hpdiff_r; // Software enables, differential
	reg [3:0] hpse_r; // Software enables, single ended
	reg [NGPIO-1:0] gpio_s1; // First synchroniser stage
	reg [NGPIO-1:0] gpio_s2; // Second synchroniser stage
	reg otp_s1; // Strap synchroniser stages
	reg otp_s2;
	reg [1:0] load_cnt; // Settling delay before the load
	// Pin-derived controls, registered to keep outputs clean
	reg [ND-1:0] pin_en;
	reg [ND-1:0] pin_stop_r;
	reg [ND-1:0] pin_stop_f;
	reg [7:0] pin_hpdiff;
	reg [3:0] pin_hpse;
	reg [ND-1:0] next_en;
	reg [ND-1:0] next_stop_r;
	reg [ND-1:0] next_stop_f;
	reg [7:0] next_hpdiff;
	reg [3:0] next_hpse;
	reg [31:0] next_rdata;
	wire [ND-1:0] run_vec; // Divider running flags
	integer i; // Loop index, configuration store only
	integer j; // Loop index, pin decode only
	integer k; // Loop index, registered outputs only

	// Both pin sets come from the board and are asynchronous
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_s1 <= {NGPIO{1'b0}};
			gpio_s2 <= {NGPIO{1'b0}};
			otp_s1 <= 1'b0;
			otp_s2 <= 1'b0;
		end else begin
			gpio_s1 <= gpio_in;
			gpio_s2 <= gpio_s1;
			otp_s1 <= otp_use;
			otp_s2 <= otp_s1;
		end
	end

	// Configuration store: defaults at reset, custom load, host writes
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			// Reset wipes every host write
			for (i = 0; i < ND; i = i + 1) begin
				ratio_r[i] <= `PDSG_RATIO_RST;
				ctrl_r[i] <= `PDSG_CTL_RST;
			end
			for (i = 0; i < NGPIO; i = i + 1) begin
				gpio_func[i] <= (i == 2) ? `PDSG_GPIO2_RST : `PDSG_GPIO_RST;
			end
			bank_r <= `PDSG_BANK_RST;
			hpdiff_r <= 8'h00;
			hpse_r <= 4'h0;
			load_cnt <= 2'h0;
			load_done <= 1'b0;
		end else if (!load_done) begin
			// Wait for the strap to pass the synchroniser, then load
			if (load_cnt == `PDSG_LOAD_WAIT) begin
				load_done <= 1'b1;
				if (otp_s2) begin
					for (i = 0; i < ND; i = i + 1) begin
						ratio_r[i] <= otp_ratio[i*23 +: 23];
						ctrl_r[i] <= otp_ctrl[i*16 +: 16];
					end
				end
			end else begin
				load_cnt <= load_cnt + 2'h1;
			end
		end else if (cfg_wr) begin
			// Host writes only after the power-up load has finished
			case (cfg_addr[7:4])
			`PDSG_A_RATIO: ratio_r[cfg_addr[3:0]] <= cfg_wdata[22:0];
			`PDSG_A_CTRL: ctrl_r[cfg_addr[3:0]] <= cfg_wdata[15:0];
			`PDSG_A_GPIO: begin
				if (cfg_addr[3:0] < NGPIO) begin
					gpio_func[cfg_addr[3:0]] <= cfg_wdata[7:0];
				end
			end
			default: begin
				if (cfg_addr == `PDSG_A_BANK) begin
					bank_r <= cfg_wdata[1:0];
				end else if (cfg_addr == `PDSG_A_HPDIFF) begin
					hpdiff_r <= cfg_wdata[7:0];
				end else if (cfg_addr == `PDSG_A_HPSE) begin
					hpse_r <= cfg_wdata[3:0];
				end
			end
			endcase
		end
	end

	// Decode pin functions; several pins may target one output
	always @* begin
		next_en = {ND{1'b0}};
		next_stop_r = {ND{1'b0}};
		next_stop_f = {ND{1'b0}};
		next_hpdiff = 8'h00;
		next_hpse = 4'h0;
		// Own loop index: sharing one with clocked code gives two drivers
		for (j = 0; j < NGPIO; j = j + 1) begin
			if (gpio_s2[j]) begin
				case (gpio_func[j][3:0])
				`PDSG_PF_HPDIFF: next_hpdiff[gpio_func[j][6:4]] = 1'b1;
				`PDSG_PF_HPSE: next_hpse[gpio_func[j][5:4]] = 1'b1;
				`PDSG_PF_DIV_EN: next_en[gpio_func[j][7:4]] = 1'b1;
				`PDSG_PF_STOP_R: next_stop_r[gpio_func[j][7:4]] = 1'b1;
				`PDSG_PF_STOP_F: next_stop_f[gpio_func[j][7:4]] = 1'b1;
				default: next_en = next_en;
				endcase
			end
		end
	end

	// Register pin controls and the combined output enables
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_en <= {ND{1'b0}};
			pin_stop_r <= {ND{1'b0}};
			pin_stop_f <= {ND{1'b0}};
			pin_hpdiff <= 8'h00;
			pin_hpse <= 4'h0;
			hp_diff_en <= 8'h00;
			hp_se_en <= 4'h0;
			bank_mode <= `PDSG_BANK_RST;
			slew_fast <= {ND{1'b0}};
		end else begin
			pin_en <= next_en;
			pin_stop_r <= next_stop_r;
			pin_stop_f <= next_stop_f;
			pin_hpdiff <= next_hpdiff;
			pin_hpse <= next_hpse;
			hp_diff_en <= hpdiff_r | pin_hpdiff;
			hp_se_en <= hpse_r | pin_hpse;
			bank_mode <= bank_r;
			for (k = 0; k < ND; k = k + 1) begin
				slew_fast[k] <= ctrl_r[k][`PDSG_CTL_SLEW];
			end
		end
	end

	assign first_hp_differential_out_en = hp_diff_en[0];

	// Divider array; a pin stop edge choice overrides the soft one
	genvar g;
	generate
		for (g = 0; g < ND; g = g + 1) begin : gen_div
			pdsg_divider u_div (
				.mclk(mclk),
				.reset_n(reset_n),
				.ratio(ratio_r[g]),
				.skew(ctrl_r[g][`PDSG_CTL_SKEW_HI:`PDSG_CTL_SKEW_LO]),
				.fine_in(ctrl_r[g][`PDSG_CTL_FINE_HI:`PDSG_CTL_FINE_LO]),
				.enable(ctrl_r[g][`PDSG_CTL_EN] | pin_en[g]),
				.stop_req(ctrl_r[g][`PDSG_CTL_STOP] | pin_stop_r[g] |
					pin_stop_f[g]),
				.stop_rise(pin_stop_r[g] | (~pin_stop_f[g] &
					ctrl_r[g][`PDSG_CTL_RISE])),
				.clk_out(div_clk[g]),
				.fine_out(fine_skew[g*3 +: 3]),
				.running(run_vec[g])
			);
		end
	endgenerate

	// Readback of configuration and status; unmapped reads zero
	always @* begin
		next_rdata = 32'h00000000;
		case (cfg_addr[7:4])
		`PDSG_A_RATIO: next_rdata = {9'h000, ratio_r[cfg_addr[3:0]]};
		`PDSG_A_CTRL: next_rdata = {16'h0000, ctrl_r[cfg_addr[3:0]]};
		`PDSG_A_GPIO: begin
			if (cfg_addr[3:0] < NGPIO) begin
				next_rdata = {24'h000000, gpio_func[cfg_addr[3:0]]};
			end
		end
		default: begin
			if (cfg_addr == `PDSG_A_BANK) begin
				next_rdata = {30'h00000000, bank_r};
			end else if (cfg_addr == `PDSG_A_HPDIFF) begin
				next_rdata = {24'h000000, hpdiff_r};
			end else if (cfg_addr == `PDSG_A_HPSE) begin
				next_rdata = {28'h0000000, hpse_r};
			end else if (cfg_addr == `PDSG_A_STAT_RUN) begin
				next_rdata = {16'h0000, run_vec};
			end else if (cfg_addr == `PDSG_A_STAT_PIN) begin
				next_rdata = {22'h000000, gpio_s2};
			end else if (cfg_addr == `PDSG_A_STAT_LOAD) begin
				next_rdata = {31'h00000000, load_done};
			end
		end
		endcase
	end

	// Read data is held until the next read strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata <= 32'h00000000;
		end else if (cfg_rd) begin
			cfg_rdata <= next_rdata;
		end
	end
endmodule // pdsg_top

// ### test/pdsg_chk_properties.sv
`timescale 1ns/10ps
// Port-level checks; divider 0 setup is shadowed from the config writes
module pdsg_chk #(
	parameter NSYN = 4,
	parameter NDIV = 4
) (
	input wire mclk,
	input wire reset_n,
	input wire otp_use,
	input wire [NSYN*NDIV*23-1:0] otp_ratio,
	input wire [NSYN*NDIV*16-1:0] otp_ctrl,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire [NSYN*NDIV-1:0] div_clk,
	input wire [NSYN*NDIV-1:0] slew_fast,
	input wire [1:0] bank_mode,
	input wire [7:0] hp_diff_en,
	input wire first_hp_differential_out_en,
	input wire load_done
);
	reg [22:0] rat0; // Divider 0 ratio
	reg [15:0] ctl0; // Divider 0 control word
	reg [7:0] hi; // High samples in this pulse
	reg [7:0] since; // Samples since a start from stop
	reg armed; // Start seen, first edge pending
	reg clean; // Pulse began with no setup change under it
	reg d0; // Divider 0 one sample back
	wire wr = cfg_wr && load_done; // Writes the block accepts
	wire wr_c0 = wr && cfg_addr == 8'h10; // Control write, divider 0
	wire go = wr_c0 && cfg_wdata[1:0] == 2'h1 && !ctl0[0]; // Start
	wire rise0 = div_clk[0] && !d0; // First high sample
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Shadow state; a setup write spoils the duty count of that pulse
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rat0 <= 23'h2;
			ctl0 <= 16'h0;
			hi <= 8'h0;
			since <= 8'h0;
			armed <= 1'b0;
			clean <= 1'b0;
			d0 <= 1'b0;
		end else begin
			d0 <= div_clk[0];
			hi <= div_clk[0] ? hi + 8'h1 : 8'h0;
			since <= go ? 8'h1 : since + 8'h1;
			armed <= go | (armed & !rise0);
			clean <= rise0 ? !wr : clean & !wr;
			// Power-up load wins until the load flag rises
			if (!load_done && otp_use) begin
				rat0 <= otp_ratio[22:0];
				ctl0 <= otp_ctrl[15:0];
			end
			if (wr && cfg_addr == 8'h00)
				rat0 <= cfg_wdata[22:0];
			if (wr_c0)
				ctl0 <= cfg_wdata[15:0];
		end
	end
	chk_load_stays: assert property (load_done |=> load_done)
		else $error("load flag dropped");
	chk_diff_mirror: assert property (
		first_hp_differential_out_en == hp_diff_en[0])
		else $error("first diff enable differs");
	// Store is written on the edge, the output flop follows one edge later
	chk_slew_write: assert property (
		wr_c0 |-> ##2 slew_fast[0] == $past(cfg_wdata[3], 2))
		else $error("slew select not taken");
	chk_bank_write: assert property (
		wr && cfg_addr == 8'h20 |-> ##2
		bank_mode == $past(cfg_wdata[1:0], 2))
		else $error("bank mode not taken");
	chk_unmapped_zero: assert property (
		cfg_rd && cfg_addr == 8'hff |=> cfg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data moved");
	chk_even_duty: assert property (
		!div_clk[0] && d0 && clean && ctl0[1:0] == 2'h1 && !rat0[0]
		&& rat0 > 23'h1 |-> hi == rat0[8:1])
		else $error("even duty wrong");
	chk_start_skew: assert property (
		armed && rise0 |-> since == ctl0[11:4] + 8'h4)
		else $error("start skew wrong");
	chk_freeze_high: assert property (
		wr_c0 && cfg_wdata[2:0] == 3'h7 && rat0 < 23'h20
		|-> ##40 div_clk[0] [*8])
		else $error("not frozen high");
	chk_park_low: assert property (
		wr_c0 && (!cfg_wdata[0] || cfg_wdata[2:0] == 3'h3)
		&& rat0 < 23'h20 |-> ##40 !div_clk[0] [*8])
		else $error("not parked low");
	cov_start: cover property (armed && rise0);
	cov_freeze: cover property (wr_c0 && cfg_wdata[2:0] == 3'h7);
	cov_otp: cover property (otp_use && $rose(load_done));
endmodule // pdsg_chk
bind pdsg_top pdsg_chk #(.NSYN(NSYN), .NDIV(NDIV)) i_chk (
	.mclk(mclk), .reset_n(reset_n), .otp_use(otp_use),
	.otp_ratio(otp_ratio), .otp_ctrl(otp_ctrl), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .div_clk(div_clk), .slew_fast(slew_fast),
	.bank_mode(bank_mode), .hp_diff_en(hp_diff_en),
	.first_hp_differential_out_en(first_hp_differential_out_en),
	.load_done(load_done));

// ### test/pdsg_clk_sink.sv
`timescale 1ns/10ps
// Board load on one output clock; keeps last rising edge time, high time, period
module pdsg_clk_sink (
	input wire clk_in,
	output reg [31:0] rise_t,
	output reg [31:0] hi_ns,
	output reg [31:0] per_ns
);
	initial begin
		rise_t = 32'h0;
		hi_ns = 32'h0;
		per_ns = 32'h0;
	end
	// A load sees only edges, so that is all it measures
	always @(posedge clk_in) begin
		per_ns <= 32'($time) - rise_t;
		rise_t <= 32'($time);
	end
	always @(negedge clk_in)
		hi_ns <= 32'($time) - rise_t;
endmodule // pdsg_clk_sink

// ### test/post_divider_skew_gating_test.sv
`timescale 1ns/10ps
module post_divider_skew_gating_test;
	reg mclk, reset_n, otp_use, cfg_wr, cfg_rd, a;
	reg [9:0] gpio_in;
	reg [367:0] otp_ratio;
	reg [255:0] otp_ctrl;
	reg [7:0] cfg_addr;
	reg [31:0] cfg_wdata, t_wr;
	wire [31:0] cfg_rdata, rise_t, hi_ns, per_ns;
	wire [15:0] div_clk, slew_fast;
	wire [47:0] fine_skew;
	wire [7:0] hp_diff_en;
	wire [3:0] hp_se_en;
	wire [1:0] bank_mode;
	wire first_hp_differential_out_en, load_done;
	integer failures, tests_run, i;
	reg [54:0] rows [0:4]; // Ratio beside the period it should give
	pdsg_top i_dut (.mclk(mclk), .reset_n(reset_n), .gpio_in(gpio_in),
		.otp_use(otp_use), .otp_ratio(otp_ratio), .otp_ctrl(otp_ctrl),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .div_clk(div_clk),
		.fine_skew(fine_skew), .slew_fast(slew_fast),
		.bank_mode(bank_mode), .hp_diff_en(hp_diff_en),
		.hp_se_en(hp_se_en), .load_done(load_done),
		.first_hp_differential_out_en(first_hp_differential_out_en));
	pdsg_clk_sink i_sink (.clk_in(div_clk[0]), .rise_t(rise_t),
		.hi_ns(hi_ns), .per_ns(per_ns));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task stop_test;
		begin
			if (failures == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("BAD %0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	// One config write; t_wr marks the edge that takes it
	task wr(input [7:0] ad, input [31:0] d);
		begin
			@(posedge mclk);
			cfg_wr <= 1'b1;
			cfg_addr <= ad;
			cfg_wdata <= d;
			@(posedge mclk);
			t_wr = 32'($time);
			cfg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] ad, input [31:0] e);
		begin
			@(posedge mclk);
			cfg_rd <= 1'b1;
			cfg_addr <= ad;
			@(posedge mclk);
			cfg_rd <= 1'b0;
			#1 chk(cfg_rdata, e);
		end
	endtask
	initial begin
		reset_n = 1'b0;
		{otp_use, cfg_wr, cfg_rd, gpio_in, cfg_addr, cfg_wdata} = 0;
		otp_ratio = 368'h0;
		otp_ctrl = 256'h0;
		failures = 0;
		tests_run = 0;
		// Every ratio of two and up gives a period of that many mclk cycles
		rows[0] = {23'h2, 32'hc8};
		rows[1] = {23'h3, 32'h12c};
		rows[2] = {23'h4, 32'h190};
		rows[3] = {23'h7, 32'h2bc};
		rows[4] = {23'h1, 32'hc8}; // Below minimum acts as two
		cyc(20);
		chk({div_clk, hp_diff_en, load_done}, 32'h0);
		reset_n <= 1'b1;
		// A write before the load flag must be dropped
		@(posedge mclk);
		cfg_wr <= 1'b1;
		cfg_addr <= 8'h22;
		cfg_wdata <= 32'hf;
		cyc(2);
		cfg_wr <= 1'b0;
		#1 chk(load_done, 0);
		@(posedge mclk);
		#1 chk(load_done, 1);
		chk(hp_se_en, 0);
		for (i = 0; i < 5; i = i + 1) begin
			wr(8'h10, 0);
			cyc(50);
			wr(8'h00, rows[i][54:32]);
			wr(8'h10, 1);
			cyc(30);
			chk(per_ns, rows[i][31:0]);
			chk(hi_ns, rows[i][31:1]);
		end
		rd(8'h42, 1);
		rd(8'hff, 0);
		rd(8'h3a, 0);
		wr(8'h20, 3);
		wr(8'h21, 8'h80);
		// Enables and slew are registered one edge behind the store
		cyc(1);
		#1 chk({bank_mode, hp_diff_en}, 10'h380);
		wr(8'h10, 16'h9);
		cyc(1);
		#1 chk(slew_fast[0], 1);
		wr(8'h10, 0);
		wr(8'h00, 20);
		cyc(50);
		wr(8'h10, 16'h51);
		cyc(12);
		chk(rise_t - t_wr, 32'h320);
		wr(8'h10, 7);
		cyc(50);
		chk(div_clk[0], 1);
		wr(8'h10, 1);
		cyc(30);
		wr(8'h10, 3);
		cyc(50);
		chk(div_clk[0], 0);
		wr(8'h10, 16'h5003);
		cyc(2);
		chk(fine_skew[2:0], 5);
		// Pin functions: stop rise, enable divider, enable se, stop fall
		wr(8'h31, 8'h14);
		wr(8'h33, 8'h23);
		wr(8'h34, 8'h02);
		wr(8'h35, 8'h35);
		wr(8'h11, 1);
		wr(8'h13, 1);
		gpio_in <= 10'h03e;
		// Look after the edge settles; divider 2 is high after even edges
		cyc(12);
		#1 chk({div_clk[3:1], hp_se_en[0]}, 4'h7);
		chk(first_hp_differential_out_en, 1);
		a = div_clk[2];
		cyc(1);
		#1 chk(div_clk[2], !a);
		rd(8'h41, 32'h3e);
		rd(8'h40, 32'h4);
		// Second reset: custom load, written values gone
		otp_use <= 1'b1;
		otp_ratio[22:0] <= 23'h6;
		otp_ctrl[15:0] <= 16'h1;
		gpio_in <= 10'h0;
		cyc(3);
		reset_n <= 1'b0;
		cyc(2);
		reset_n <= 1'b1;
		for (i = 0; i < 10 && load_done !== 1'b1; i = i + 1)
			cyc(1);
		// A load flag that never rises counts as a mismatch
		if (i >= 10) begin
			failures = failures + 1;
		end else begin
			cyc(30);
			chk(bank_mode, 0);
			chk(per_ns, 32'h258);
		end
		stop_test;
	end
endmodule // post_divider_skew_gating_test
